//--- design/tag_block_store.sv
// nonvolatile block store: 128 blocks (OTP, counters, user) plus the system block
`timescale 1ns/1ps
module tag_block_store (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_factory_init,
   input wire logic [7:0] i_fixed_id,
   input wire logic i_fixed_id_fitted,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_index,
   input wire logic [31:0] i_wr_word,
   input wire logic [7:0] i_look_index,
   output logic [31:0] o_look_word,
   output logic [31:0] o_sys_word,
   input wire logic i_rd_en,
   input wire logic [7:0] i_rd_index,
   output logic [31:0] o_rd_data
);
   import tag_policy_pkg::*;

   typedef struct packed {
      logic [STORE_WORDS-1:0][31:0] mem;
      logic [31:0] rd_data;
   } store_state_t;

   store_state_t st;
   store_state_t next_st;

   always_comb begin
      next_st = st;
      if (i_factory_init) begin
         for (int i = 0; i < STORE_WORDS; i++) begin
            next_st.mem[i] = BLANK_WORD;
         end
         next_st.mem[FIRST_DOWN_COUNTER] = FIRST_COUNTER_INIT;
         next_st.mem[SECOND_DOWN_COUNTER] = SECOND_COUNTER_INIT;
         next_st.mem[SYS_INDEX][ID_MSB:ID_LSB] = i_fixed_id_fitted ? i_fixed_id : BLANK_ID;
      end else if (i_wr_en && i_wr_index < 8'(STORE_WORDS)) begin
         next_st.mem[i_wr_index] = i_wr_word;
      end
      // cell contents survive reset; only the read latch clears
      if (i_rst) begin
         next_st.rd_data = EMPTY_WORD;
      end else if (i_rd_en) begin
         next_st.rd_data = (i_rd_index < 8'(STORE_WORDS)) ? st.mem[i_rd_index] : EMPTY_WORD;
      end
   end

   always_ff @(posedge i_core_clk) begin
      st <= next_st;
   end

   assign o_look_word = (i_look_index < 8'(STORE_WORDS)) ? st.mem[i_look_index] : EMPTY_WORD;
   assign o_sys_word = st.mem[SYS_INDEX];
   assign o_rd_data = st.rd_data;

endmodule

//--- design/tag_block_write_policy.sv
// write access policy for the tag block memory, with read path and selection id
`timescale 1ns/1ps
module tag_block_write_policy #(
   parameter int unsigned ERASE_CYCLES = tag_policy_pkg::ERASE_CYCLES_DEFAULT,
   parameter int unsigned PROG_CYCLES = tag_policy_pkg::PROG_CYCLES_DEFAULT,
   parameter logic FIXED_ID_FITTED = 1'b0,
   parameter logic [7:0] FIXED_ID = 8'h5A
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_factory_init,
   input wire logic i_power_fail,
   input wire logic i_select,
   input wire logic i_wr_req,
   input wire logic [7:0] i_wr_addr,
   input wire logic [31:0] i_wr_data,
   output logic o_wr_ready,
   output logic o_wr_done,
   output logic o_wr_rejected,
   output logic o_prog_busy,
   output logic o_erase_active,
   output logic o_refill_armed,
   input wire logic i_rd_req,
   input wire logic [7:0] i_rd_addr,
   output logic o_rd_valid,
   output logic o_rd_unmapped,
   output logic [31:0] o_rd_data,
   input wire logic i_id_refresh,
   input wire logic [7:0] i_random_id,
   output logic o_random_id_enable,
   output logic [7:0] o_selection_id
);
   import tag_policy_pkg::*;

   // ******************************************************************
   // elaboration checks
   // ******************************************************************
   if (ERASE_CYCLES < 1 || ERASE_CYCLES > CYCLE_CNT_MAX) begin : g_bad_erase
      $error("ERASE_CYCLES out of range");
   end
   if (PROG_CYCLES < 1 || PROG_CYCLES > CYCLE_CNT_MAX) begin : g_bad_prog
      $error("PROG_CYCLES out of range");
   end
   // the system block must sit inside the store array
   if (SYS_INDEX >= STORE_WORDS) begin : g_bad_store
      $error("system block index outside the store");
   end

   localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);
   localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

   typedef struct packed {
      prog_state_t state;
      logic [15:0] cnt;
      logic [7:0] index;
      logic [31:0] word;
      logic arm_on_commit;
      logic refill_armed;
      logic done;
      logic rejected;
      logic rd_valid;
      logic rd_unmapped;
      logic [7:0] sel_id;
      logic id_load_pending;
   } policy_state_t;

   policy_state_t st;
   policy_state_t next_st;

   logic [31:0] look_word;
   logic [31:0] sys_word;
   logic [7:0] look_index;
   logic commit_now;
   logic abort;
   logic accept;
   logic need_erase;
   logic [31:0] final_word;
   logic arm_hit;
   logic refill_set;
   logic refill_clear;

   assign look_index = block_index(i_wr_addr);
   assign abort = i_power_fail || i_factory_init;
   assign refill_set = commit_now && st.arm_on_commit;
   assign refill_clear = i_select || i_power_fail;

   // ******************************************************************
   // area policy for a request in the idle state
   // ******************************************************************
   always_comb begin
      accept = 1'b0;
      need_erase = 1'b0;
      final_word = look_word;
      arm_hit = 1'b0;
      if (i_wr_addr <= OTP_LAST) begin
         if (st.refill_armed) begin
            accept = 1'b1;
            need_erase = 1'b1;
            final_word = i_wr_data;
         end else begin
            accept = (look_word != EMPTY_WORD);
            final_word = look_word & i_wr_data;
         end
      end else if (i_wr_addr == FIRST_DOWN_COUNTER || i_wr_addr == SECOND_DOWN_COUNTER) begin
         accept = (i_wr_data < look_word);
         need_erase = 1'b1;
         final_word = i_wr_data;
         arm_hit = (i_wr_addr == SECOND_DOWN_COUNTER) &&
                   (i_wr_data[REFILL_MSB:REFILL_LSB] != look_word[REFILL_MSB:REFILL_LSB]);
      end else if (i_wr_addr <= USER_LAST) begin
         accept = !is_protected(i_wr_addr, sys_word[LOCK_MSB:LOCK_LSB]);
         need_erase = 1'b1;
         final_word = i_wr_data;
      end else if (i_wr_addr == BLOCK_WRITE_PROTECT_BITS) begin
         accept = (look_word != EMPTY_WORD);
         final_word = look_word & i_wr_data;
         // mask-set id bits are not writable
         if (FIXED_ID_FITTED) begin
            final_word[ID_MSB:ID_LSB] = look_word[ID_MSB:ID_LSB];
         end
      end
   end

   // one commit edge, so a cut cycle never leaves half a word
   // commit only at end of cycle
   assign commit_now = (st.state == PROG_WRITE) && (st.cnt == 16'h0000) && !abort && !i_rst;

   // ******************************************************************
   // programming sequencer
   // ******************************************************************
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.rejected = 1'b0;
      next_st.rd_valid = 1'b0;
      unique case (st.state)
         PROG_IDLE: begin
            if (i_wr_req && !i_factory_init) begin
               if (!accept) begin
                  next_st.done = 1'b1;
                  next_st.rejected = 1'b1;
               end else begin
                  next_st.index = look_index;
                  next_st.word = final_word;
                  // arming waits for the commit, so a torn write never arms
                  next_st.arm_on_commit = arm_hit;
                  next_st.state = need_erase ? PROG_ERASE : PROG_WRITE;
                  next_st.cnt = need_erase ? ERASE_LAST : PROG_LAST;
               end
            end
         end
         PROG_ERASE: begin
            if (st.cnt == 16'h0000) begin
               next_st.state = PROG_WRITE;
               next_st.cnt = PROG_LAST;
            end else begin
               next_st.cnt = st.cnt - 16'h0001;
            end
         end
         PROG_WRITE: begin
            if (st.cnt == 16'h0000) begin
               next_st.state = PROG_IDLE;
               next_st.done = 1'b1;
            end else begin
               next_st.cnt = st.cnt - 16'h0001;
            end
         end
         // the fourth code of the state register is never entered
         default: begin
            next_st.state = PROG_IDLE;
         end
      endcase

      // ******************************************************************
      // torn cycle
      // ******************************************************************
      // no partial word reaches the store, counters and storage alike
      // torn cycle leaves old contents
      if (abort && st.state != PROG_IDLE) begin
         next_st.state = PROG_IDLE;
         next_st.cnt = 16'h0000;
         next_st.done = 1'b0;
      end

      // ******************************************************************
      // refill arm
      // ******************************************************************
      // select or power loss clears
      // arm on committed change, set wins
      if (refill_set) begin
         next_st.refill_armed = 1'b1;
      end else if (refill_clear) begin
         next_st.refill_armed = 1'b0;
      end

      // ******************************************************************
      // read path
      // ******************************************************************
      // reads are served while busy; the old word shows until commit
      // every mapped block readable
      if (i_rd_req) begin
         next_st.rd_valid = 1'b1;
         next_st.rd_unmapped = !is_mapped(i_rd_addr);
      end

      // ******************************************************************
      // selection id
      // ******************************************************************
      // fixed id beats random id
      if (st.id_load_pending || i_id_refresh) begin
         next_st.sel_id = FIXED_ID_FITTED ? FIXED_ID : i_random_id;
         next_st.id_load_pending = 1'b0;
      end

      // ******************************************************************
      // reset values
      // ******************************************************************
      if (i_rst) begin
         next_st.state = PROG_IDLE;
         next_st.cnt = 16'h0000;
         next_st.index = 8'h00;
         next_st.word = EMPTY_WORD;
         next_st.arm_on_commit = 1'b0;
         next_st.refill_armed = 1'b0;
         next_st.done = 1'b0;
         next_st.rejected = 1'b0;
         next_st.rd_valid = 1'b0;
         next_st.rd_unmapped = 1'b0;
         next_st.sel_id = 8'h00;
         // id is caught after release, never at reset
         next_st.id_load_pending = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      st <= next_st;
   end

   // ******************************************************************
   // block store
   // ******************************************************************
   // factory delivery values
   tag_block_store u_store (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_factory_init(i_factory_init),
      .i_fixed_id(FIXED_ID),
      .i_fixed_id_fitted(FIXED_ID_FITTED),
      .i_wr_en(commit_now),
      .i_wr_index(st.index),
      .i_wr_word(st.word),
      .i_look_index(look_index),
      .o_look_word(look_word),
      .o_sys_word(sys_word),
      .i_rd_en(i_rd_req),
      .i_rd_index(block_index(i_rd_addr)),
      .o_rd_data(o_rd_data)
   );

   // ******************************************************************
   // outputs
   // ******************************************************************
   // nothing is taken while reset still holds the state
   assign o_wr_ready = (st.state == PROG_IDLE) && !i_rst;
   assign o_wr_done = st.done;
   assign o_wr_rejected = st.rejected;
   assign o_prog_busy = (st.state != PROG_IDLE);
   assign o_erase_active = (st.state == PROG_ERASE);
   assign o_refill_armed = st.refill_armed;
   assign o_rd_valid = st.rd_valid;
   assign o_rd_unmapped = st.rd_unmapped;
   assign o_random_id_enable = !FIXED_ID_FITTED;
   assign o_selection_id = st.sel_id;

endmodule

//--- design/tag_policy_pkg.sv
// constants, types and helpers shared by the block write policy and its block store
package tag_policy_pkg;

   // ******************************************************************
   // block map
   // ******************************************************************
   localparam int unsigned BLOCK_W = 32;
   localparam int unsigned STORE_WORDS = 129;
   localparam logic [7:0] OTP_FIRST = 8'h00;
   localparam logic [7:0] OTP_LAST = 8'h04;
   localparam logic [7:0] FIRST_DOWN_COUNTER = 8'h05;
   localparam logic [7:0] SECOND_DOWN_COUNTER = 8'h06;
   localparam logic [7:0] USER_FIRST = 8'h07;
   localparam logic [7:0] LOCK_PAIR_LAST = 8'h08;
   localparam logic [7:0] LOCKABLE_LAST = 8'h0F;
   localparam logic [7:0] USER_LAST = 8'h7F;
   localparam logic [7:0] BLOCK_WRITE_PROTECT_BITS = 8'hFF;
   localparam logic [7:0] SYS_INDEX = 8'h80;

   // ******************************************************************
   // values after factory delivery and field layout
   // ******************************************************************
   localparam logic [31:0] FIRST_COUNTER_INIT = 32'hFFFF_FFFE;
   localparam logic [31:0] SECOND_COUNTER_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] BLANK_WORD = 32'hFFFF_FFFF;
   localparam logic [31:0] EMPTY_WORD = 32'h0000_0000;
   localparam logic [7:0] BLANK_ID = 8'hFF;
   localparam int unsigned LOCK_LSB = 24;
   localparam int unsigned LOCK_MSB = 31;
   localparam int unsigned REFILL_LSB = 21;
   localparam int unsigned REFILL_MSB = 31;
   localparam int unsigned ID_LSB = 0;
   localparam int unsigned ID_MSB = 7;

   // ******************************************************************
   // programming cycle lengths in clock cycles
   // ******************************************************************
   localparam int unsigned ERASE_CYCLES_DEFAULT = 16;
   localparam int unsigned PROG_CYCLES_DEFAULT = 32;
   localparam int unsigned CYCLE_CNT_MAX = 65535;

   typedef enum logic [1:0] {
      PROG_IDLE,
      PROG_ERASE,
      PROG_WRITE
   } prog_state_t;

   // block address to store index; 8'hFF for unmapped
   function automatic logic [7:0] block_index(input logic [7:0] addr);
      if (addr <= USER_LAST) begin
         return addr;
      end else if (addr == BLOCK_WRITE_PROTECT_BITS) begin
         return SYS_INDEX;
      end
      return 8'hFF;
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr <= USER_LAST) || (addr == BLOCK_WRITE_PROTECT_BITS);
   endfunction

   // a zero flag protects its block; one flag covers the first pair
   function automatic logic is_protected(input logic [7:0] addr, input logic [7:0] lock);
      if (addr < USER_FIRST || addr > LOCKABLE_LAST) begin
         return 1'b0;
      end else if (addr <= LOCK_PAIR_LAST) begin
         return ~lock[0];
      end
      return ~lock[3'(addr - LOCK_PAIR_LAST)];
   endfunction

endpackage

//--- sim/tag_block_write_policy_tb.sv
// self-checking bench for the block write policy
`timescale 1ns/1ps
module tag_block_write_policy_tb;
   import tag_policy_pkg::*;
   localparam int unsigned EC = 2;
   localparam int unsigned PC = 3;
   localparam int LE = EC + PC + 1;
   localparam int LP = PC + 1;
   localparam int J = 1;
   // arbitrary fixed id for the instance with the option fitted
   localparam logic [7:0] FX_ID = 8'h3C;
   logic [7:0] fx_sel_id;
   logic [31:0] fx_rd_data;
   logic fx_rnd_en;
   logic i_core_clk = 1'b0;
   logic i_rst, i_factory_init, i_power_fail, i_select, i_wr_req, i_rd_req, i_id_refresh;
   logic [7:0] i_wr_addr, i_rd_addr, i_random_id, o_selection_id;
   logic [31:0] i_wr_data, o_rd_data;
   logic o_wr_ready, o_wr_done, o_wr_rejected, o_prog_busy, o_erase_active, o_refill_armed;
   logic o_rd_valid, o_rd_unmapped, o_random_id_enable;
   int error_cnt = 0;
   int checks_done = 0;
   always #5 i_core_clk = ~i_core_clk;
   tag_block_write_policy #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) i_dut (.*);
   // second instance with the fixed id fitted; it shares all stimulus
   tag_block_write_policy #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC), .FIXED_ID_FITTED(1'b1), .FIXED_ID(FX_ID)) i_dut_fix (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_factory_init(i_factory_init), .i_power_fail(i_power_fail),
      .i_select(i_select), .i_wr_req(i_wr_req), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .o_wr_ready(),
      .o_wr_done(), .o_wr_rejected(), .o_prog_busy(), .o_erase_active(), .o_refill_armed(),
      .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr), .o_rd_valid(), .o_rd_unmapped(), .o_rd_data(fx_rd_data),
      .i_id_refresh(i_id_refresh), .i_random_id(i_random_id), .o_random_id_enable(fx_rnd_en),
      .o_selection_id(fx_sel_id));
   tag_decoder_model i_prt (.i_core_clk(i_core_clk), .i_wr_done(o_wr_done), .i_wr_rejected(o_wr_rejected),
      .i_rd_unmapped(o_rd_unmapped), .i_rd_data(o_rd_data), .o_wr_req(i_wr_req), .o_wr_addr(i_wr_addr),
      .o_wr_data(i_wr_data), .o_rd_req(i_rd_req), .o_rd_addr(i_rd_addr), .o_power_fail(i_power_fail),
      .o_id_refresh(i_id_refresh), .o_random_id(i_random_id));
   // ******************************************************************
   // shared access and compare tasks
   // ******************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d, input int lat);
      logic rej;
      int got;
      i_prt.wr(a, d, 1'b0, rej, got);
      chk("wr_rejected", 32'(rej), 32'(lat == J));
      chk("wr_latency", 32'(got), 32'(lat));
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic u;
      i_prt.rd(a, d, u);
      chk("rd_data", d, exp);
      chk("rd_unmapped", 32'(u), 32'(a[7] && a != 8'hFF));
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      finish_test();
   end
   initial begin
      logic rej;
      int got;
      i_rst = 1'b1;
      i_factory_init = 1'b0;
      i_select = 1'b0;
      repeat (2) @(negedge i_core_clk);
      i_rst = 1'b0;
      i_factory_init = 1'b1;
      @(negedge i_core_clk);
      i_factory_init = 1'b0;
      r(FIRST_DOWN_COUNTER, 32'hFFFF_FFFE);
      r(SECOND_DOWN_COUNTER, BLANK_WORD);
      w(8'h01, 32'hF0F0_1234, LP);
      w(8'h01, 32'h0FF0_0230, LP);
      r(8'h01, 32'h00F0_0230);
      w(8'h01, EMPTY_WORD, LP);
      w(8'h01, BLANK_WORD, J);
      r(8'h01, EMPTY_WORD);
      w(FIRST_DOWN_COUNTER, 32'hFFFF_FFFE, J);
      w(FIRST_DOWN_COUNTER, 32'h0000_0010, LE);
      w(FIRST_DOWN_COUNTER, 32'h0000_0011, J);
      r(FIRST_DOWN_COUNTER, 32'h0000_0010);
      w(FIRST_DOWN_COUNTER, EMPTY_WORD, LE);
      w(FIRST_DOWN_COUNTER, 32'h0000_0001, J);
      r(FIRST_DOWN_COUNTER, EMPTY_WORD);
      i_prt.wr(SECOND_DOWN_COUNTER, 32'h0000_0005, 1'b1, rej, got);
      r(SECOND_DOWN_COUNTER, BLANK_WORD);
      w(SECOND_DOWN_COUNTER, 32'hFFFF_0000, LE);
      chk("refill_armed", 32'(o_refill_armed), EMPTY_WORD);
      w(SECOND_DOWN_COUNTER, 32'hFFDF_0000, LE);
      chk("refill_armed", 32'(o_refill_armed), 32'h0000_0001);
      w(8'h01, 32'h1234_5678, LE);
      r(8'h01, 32'h1234_5678);
      @(negedge i_core_clk);
      i_select = 1'b1;
      @(negedge i_core_clk);
      i_select = 1'b0;
      chk("refill_armed", 32'(o_refill_armed), EMPTY_WORD);
      w(8'h01, 32'h0000_FFFF, LP);
      r(8'h01, 32'h0000_5678);
      w(SECOND_DOWN_COUNTER, 32'hFFBF_0000, LE);
      chk("refill_armed", 32'(o_refill_armed), 32'h0000_0001);
      i_prt.wr(8'h14, 32'h1111_1111, 1'b1, rej, got);
      chk("refill_armed", 32'(o_refill_armed), EMPTY_WORD);
      r(8'h14, BLANK_WORD);
      w(8'h14, 32'hA5A5_0F0F, LE);
      w(8'h14, 32'h5A5A_F0F0, LE);
      r(8'h14, 32'h5A5A_F0F0);
      w(BLOCK_WRITE_PROTECT_BITS, 32'hFEFF_FFFF, LP);
      r(BLOCK_WRITE_PROTECT_BITS, 32'hFEFF_FFFF);
      w(8'h07, EMPTY_WORD, J);
      w(8'h08, EMPTY_WORD, J);
      r(8'h07, BLANK_WORD);
      for (int k = 1; k <= 7; k++) begin
         w(8'(8 + k), 32'hC0DE_0000 | 32'(k), LE);
         w(BLOCK_WRITE_PROTECT_BITS, ~(32'h0100_0000 << k), LP);
         w(8'(8 + k), EMPTY_WORD, J);
         r(8'(8 + k), 32'hC0DE_0000 | 32'(k));
      end
      w(BLOCK_WRITE_PROTECT_BITS, EMPTY_WORD, LP);
      w(BLOCK_WRITE_PROTECT_BITS, BLANK_WORD, J);
      r(BLOCK_WRITE_PROTECT_BITS, EMPTY_WORD);
      chk("fixed_id_block", fx_rd_data, 32'(FX_ID));
      r(8'h80, EMPTY_WORD);
      w(8'h90, EMPTY_WORD, J);
      i_prt.refresh();
      chk("random_id_enable", 32'(o_random_id_enable), 32'h0000_0001);
      chk("fixed_sel_id", 32'(fx_sel_id), 32'(FX_ID));
      chk("fixed_rnd_en", 32'(fx_rnd_en), EMPTY_WORD);
      finish_test();
   end
endmodule

//--- sim/tag_decoder_model.sv
// command decoder model issuing block reads, writes and id refreshes
`timescale 1ns/1ps
module tag_decoder_model (
   input wire logic i_core_clk,
   input wire logic i_wr_done,
   input wire logic i_wr_rejected,
   input wire logic i_rd_unmapped,
   input wire logic [31:0] i_rd_data,
   output logic o_wr_req,
   output logic [7:0] o_wr_addr,
   output logic [31:0] o_wr_data,
   output logic o_rd_req,
   output logic [7:0] o_rd_addr,
   output logic o_power_fail,
   output logic o_id_refresh,
   output logic [7:0] o_random_id
);
   initial begin
      {o_wr_req, o_rd_req, o_power_fail, o_id_refresh} = 4'h0;
      {o_wr_addr, o_rd_addr, o_random_id} = 24'h0000_11;
      o_wr_data = 32'h0000_0000;
   end
   // random source moves every cycle so a stale capture shows
   always @(negedge i_core_clk) begin
      o_random_id <= o_random_id + 8'h3B;
   end
   // tear drops power in the second busy cycle and gives up
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic tear, output logic rej, output int lat);
      rej = 1'b1;
      lat = 0;
      @(negedge i_core_clk);
      o_wr_req = 1'b1;
      o_wr_addr = a;
      o_wr_data = d;
      for (int k = 1; k <= 20; k++) begin
         @(negedge i_core_clk);
         o_wr_req = 1'b0;
         o_wr_addr = ~a;
         o_wr_data = ~d;
         o_power_fail = tear && (k == 2);
         if (i_wr_done === 1'b1 || (tear && k == 3)) begin
            rej = i_wr_rejected;
            lat = k;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic u);
      @(negedge i_core_clk);
      o_rd_req = 1'b1;
      o_rd_addr = a;
      @(negedge i_core_clk);
      o_rd_req = 1'b0;
      o_rd_addr = ~a;
      d = i_rd_data;
      u = i_rd_unmapped;
   endtask
   task automatic refresh();
      @(negedge i_core_clk);
      o_id_refresh = 1'b1;
      @(negedge i_core_clk);
      o_id_refresh = 1'b0;
   endtask
endmodule

//--- sim/tag_policy_chk.sv
// assertion checker bound to the block write policy ports
`timescale 1ns/1ps
module tag_policy_chk #(
   parameter int unsigned ERASE_CYCLES = 1,
   parameter int unsigned PROG_CYCLES = 1,
   parameter logic FIXED_ID_FITTED = 1'b0,
   parameter logic [7:0] FIXED_ID = 8'h00
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_factory_init,
   input wire logic i_power_fail,
   input wire logic i_select,
   input wire logic i_wr_req,
   input wire logic o_wr_ready,
   input wire logic o_wr_done,
   input wire logic o_wr_rejected,
   input wire logic o_prog_busy,
   input wire logic o_erase_active,
   input wire logic o_refill_armed,
   input wire logic i_rd_req,
   input wire logic [7:0] i_rd_addr,
   input wire logic o_rd_valid,
   input wire logic o_rd_unmapped,
   input wire logic [31:0] o_rd_data,
   input wire logic i_id_refresh,
   input wire logic [7:0] i_random_id,
   input wire logic o_random_id_enable,
   input wire logic [7:0] o_selection_id
);
   logic [7:0] bcnt;
   logic [7:0] ecnt;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // ******************************************************************
   // phase length counters, cleared whenever the block is idle
   // ******************************************************************
   always_ff @(posedge i_core_clk) begin
      bcnt <= o_prog_busy ? bcnt + 8'h01 : 8'h00;
      ecnt <= o_erase_active ? ecnt + 8'h01 : (o_prog_busy ? ecnt : 8'h00);
   end
   sequence s_take;
      i_wr_req && o_wr_ready && !i_factory_init;
   endsequence
   sequence s_answer;
      (o_wr_done && o_wr_rejected) || (o_prog_busy && !o_wr_done);
   endsequence
   property p_take; s_take |=> s_answer; endproperty
   property p_len; o_wr_done && !o_wr_rejected |-> (bcnt == 8'(PROG_CYCLES) && ecnt == 8'h00) ||
      (ecnt == 8'(ERASE_CYCLES) && bcnt == 8'(ERASE_CYCLES + PROG_CYCLES)); endproperty
   property p_abort; o_prog_busy && i_power_fail |=> !o_prog_busy && !o_wr_done; endproperty
   property p_rd; i_rd_req |=> o_rd_valid; endproperty
   property p_unm; i_rd_req && i_rd_addr[7] && i_rd_addr != 8'hFF |=>
      o_rd_unmapped && o_rd_data == 32'h0000_0000; endproperty
   property p_disarm; i_select || i_power_fail |=> !o_refill_armed || (o_wr_done && !o_wr_rejected); endproperty
   property p_keep; o_refill_armed && !i_select && !i_power_fail |=> o_refill_armed; endproperty
   property p_arm; $rose(o_refill_armed) |-> o_wr_done && !o_wr_rejected; endproperty
   property p_id; i_id_refresh |=> o_selection_id == (FIXED_ID_FITTED ? FIXED_ID : $past(i_random_id)); endproperty
   property p_rnd_en; o_random_id_enable == !FIXED_ID_FITTED; endproperty
   a_take: assert property (p_take) else $error("write request answered wrongly");
   a_len: assert property (p_len) else $error("programming phases have wrong length");
   a_abort: assert property (p_abort) else $error("torn cycle went on or committed");
   a_rd: assert property (p_rd) else $error("read not answered");
   a_unm: assert property (p_unm) else $error("unmapped read not flagged");
   a_disarm: assert property (p_disarm) else $error("refill stayed armed");
   a_keep: assert property (p_keep) else $error("refill dropped by itself");
   a_arm: assert property (p_arm) else $error("refill armed without a commit");
   a_id: assert property (p_id) else $error("selection id not reloaded");
   a_rnd_en: assert property (p_rnd_en) else $error("random id enable wrong");
endmodule
bind tag_block_write_policy tag_policy_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES),
   .FIXED_ID_FITTED(FIXED_ID_FITTED), .FIXED_ID(FIXED_ID)) i_chk (.*);
